// ===== logic/tdc_codec.sv
// Transfer descriptor codec: buffer RAM plus a sequencer that walks
// descriptor lists, hands each transfer to the link engine and writes back.
// Assumes a link engine that reports a result and byte count per transfer.
//
// Functional notes
// RULE1: Each header is eight bytes: type, destination and size of one transfer.
// RULE2: A record is its header followed directly by its payload bytes.
// RULE3: Every record starts on a 32-bit word boundary.
// RULE4: Driver prepares each frame's buffers; each payload has its own header.
// RULE5: Driver copies whole records into buffer RAM before the codec acts.
// RULE6: Transactions are chosen only from records held in buffer RAM.
// RULE7: Status and response data go back into buffer RAM in header form.
// RULE8: Ten-bit moved count written: low eight in byte 0, top two in byte 1.
// RULE9: Status 0000 when the transfer ended with no detected error.
// RULE10: Status 0001 when the last received data packet failed CRC.
// RULE11: Status 0010 when the last data packet broke bit stuffing.
// RULE12: Status 0011 when the received data toggle was not the expected one.
// RULE13: Status 0100 when the endpoint answered STALL.
// RULE14: Status 0101 when there was no response or no handshake.
// RULE15: Codes 0110, 0111, 1000, 1001, 1100, 1101 for PID and overrun faults.
// RULE16: Software sets active; codec clears it on completion so it is skipped.
// RULE17: Toggle flag is updated after a data packet is received.
// RULE18: Header fields sit at the fixed byte and bit positions listed.
// RULE19: Records run in order; the list stops at the one marked last.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module tdc_codec
   import tdc_pkg::*;
(
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst,
   // Register port
   input  wire logic [7:0]   reg_addr,
   input  wire logic [31:0]  reg_wdata,
   input  wire logic         reg_write,
   input  wire logic         reg_read,
   output logic      [31:0]  reg_rdata,
   // Transfer request to link engine
   output logic              xfer_req,
   output logic      [3:0]   xfer_endpoint_index,
   output logic      [6:0]   xfer_device_address_field,
   output logic      [1:0]   xfer_pid,
   output logic              xfer_dir_in,
   output logic              xfer_speed,
   output logic              xfer_format,
   output logic              xfer_toggle,
   output logic      [9:0]   xfer_max_packet_length,
   output logic      [9:0]   xfer_requested_length,
   // Payload stream, one word per cycle
   output logic      [31:0]  tx_data,
   input  wire logic         tx_take,
   input  wire logic         rx_valid,
   input  wire logic [31:0]  rx_data,
   // Result from link engine
   input  wire logic         xfer_done,
   input  wire logic [3:0]   xfer_status,
   input  wire logic [9:0]   xfer_count,
   input  wire logic         xfer_data_rx,
   input  wire logic         xfer_toggle_next,
   // Status
   output logic              list_busy
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   tdc_state_type     state_q;
   logic [RAM_AW-1:0] sw_ptr_q;
   logic [RAM_AW-1:0] desc_q;
   logic [RAM_AW-1:0] pay_q;
   logic [31:0]       hdr0_q;
   logic [31:0]       hdr1_q;
   logic [3:0]        status_q;
   logic [9:0]        count_q;
   logic              toggle_q;
   logic              fault_q;
   logic              start_pulse;
   logic              sw_we;
   logic [31:0]       sw_rdata;
   logic [RAM_AW-1:0] b_addr;
   logic              b_we;
   logic [31:0]       b_wdata;
   logic [31:0]       b_rdata;
   logic [RAM_AW-1:0] rec_words;
   logic [3:0]        done_status;
   logic [9:0]        hdr_len;

   // ------------------------------------------------------------
   // Buffer RAM
   // ------------------------------------------------------------
   // Software owns port a, the sequencer port b
   tdc_ram u_ram (
      .clock   (clock),
      .rst     (rst),
      .a_addr  (sw_ptr_q),
      .a_we    (sw_we),
      .a_wdata (reg_wdata),
      .a_rdata (sw_rdata),
      .b_addr  (b_addr),
      .b_we    (b_we),
      .b_wdata (b_wdata),
      .b_rdata (b_rdata)
   );

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   // Word writes only, so records land on word boundaries [RULE3]
   assign sw_we       = reg_write && reg_addr == REG_RAM_DATA;
   assign start_pulse = reg_write && reg_addr == REG_CONTROL && reg_wdata[CTL_START];

   // Pointer auto-increments on each data access for block copies [RULE5]
   // The pointer wraps at the RAM end, so a block copy must fit in it
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         sw_ptr_q <= '0;
      else if (reg_write && reg_addr == REG_RAM_PTR)
         sw_ptr_q <= reg_wdata[RAM_AW-1:0];
      else if (sw_we || (reg_read && reg_addr == REG_RAM_DATA))
         sw_ptr_q <= sw_ptr_q + RAM_AW'(1);
   end

   // Read data one cycle after the strobe; unmapped reads give zero
   // Zero outside the answer cycle, so a stale word is never read twice
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         reg_rdata <= RESET_VALUE;
      else if (reg_read)
      begin
         case (reg_addr)
            REG_CONTROL:  reg_rdata <= {31'h0, list_busy};
            REG_STATUS:   reg_rdata <= {18'h0, fault_q, state_q, status_q, 6'h0};
            REG_RAM_PTR:  reg_rdata <= {26'h0, sw_ptr_q};
            REG_RAM_DATA: reg_rdata <= sw_rdata;
            REG_CUR_DESC: reg_rdata <= {26'h0, desc_q};
            default:      reg_rdata <= RESET_VALUE;
         endcase
      end
      else
         reg_rdata <= RESET_VALUE;
   end

   // ------------------------------------------------------------
   // Header decode
   // ------------------------------------------------------------
   // Field positions of the two header words [RULE18] [RULE1]
   assign hdr_len   = {hdr1_q[9:8], hdr1_q[7:0]};
   // Header is two words, then payload rounded up to words [RULE2] [RULE3]
   // Lengths from 1021 up wrap the rounding adder; keep records shorter
   assign rec_words = RAM_AW'(2) + RAM_AW'((hdr_len + 10'h3) >> 2);

   // Request fields are levels held from request until write-back
   assign xfer_max_packet_length    = {hdr0_q[25:24], hdr0_q[23:16]};
   assign xfer_endpoint_index       = hdr0_q[31:28];
   assign xfer_speed                = hdr0_q[24 + BIT_SPEED];
   assign xfer_requested_length     = hdr_len;
   assign xfer_dir_in               = hdr1_q[8 + BIT_DIR];
   assign xfer_pid                  = hdr1_q[11:10];
   assign xfer_format               = hdr1_q[23];
   assign xfer_device_address_field = hdr1_q[22:16];
   assign xfer_toggle               = hdr0_q[8 + BIT_TOGGLE];
   assign xfer_req                  = state_q == ST_ISSUE;
   assign list_busy                 = state_q != ST_IDLE;
   assign tx_data                   = b_rdata;

   // Only the listed codes are passed; reserved ones fold to bad PID
   always_comb
   begin
      case (xfer_status)
         status_ok, status_crc, status_stuff_violation,
         status_toggle_mismatch, status_stall, status_no_response,
         status_pid_check_fail, status_bad_pid, status_data_over,
         status_data_under, status_buffer_over,
         status_buffer_under: done_status = xfer_status; // [RULE9] [RULE10] [RULE11] [RULE12] [RULE13] [RULE14] [RULE15]
         default:             done_status = status_bad_pid;
      endcase
   end

   // ------------------------------------------------------------
   // RAM port b steering
   // ------------------------------------------------------------
   always_comb
   begin
      b_addr  = desc_q;
      b_we    = 1'b0;
      b_wdata = hdr0_q;
      case (state_q)
         // Idle looks at word zero so the start edge loads the first header
         ST_IDLE:  b_addr = '0;
         ST_FETCH: b_addr = desc_q + RAM_AW'(1);
         // Next looks ahead so the following header is ready on the move
         ST_NEXT:  b_addr = desc_q + rec_words;
         ST_WAIT,
         ST_MOVE:
         begin
            b_addr  = pay_q;
            b_we    = rx_valid;            // Response data into payload [RULE7]
            b_wdata = rx_data;
         end
         ST_WBACK:
         begin
            b_we    = 1'b1;
            // Count split over bytes 0 and 1, active cleared [RULE8] [RULE16] [RULE7]
            b_wdata = {hdr0_q[31:16], status_q, 1'b0, toggle_q,
                       count_q[9:8], count_q[7:0]};
         end
         default: b_addr = desc_q;
      endcase
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // Walks records in order from word zero [RULE6] [RULE19]
   // One transfer is open at a time, so requests never overlap on the link
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         desc_q  <= '0;
         pay_q   <= '0;
         hdr0_q  <= RESET_VALUE;
         hdr1_q  <= RESET_VALUE;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
               if (start_pulse)
               begin
                  desc_q  <= '0;
                  hdr0_q  <= b_rdata;
                  state_q <= ST_FETCH;
               end
            ST_FETCH:
            begin
               hdr1_q  <= b_rdata;
               pay_q   <= desc_q + RAM_AW'(2);
               // Inactive records are skipped untouched [RULE16]
               state_q <= hdr0_q[8 + BIT_ACTIVE] ? ST_ISSUE : ST_NEXT;
            end
            ST_ISSUE: state_q <= ST_WAIT;
            ST_WAIT,
            ST_MOVE:
            begin
               if (tx_take || rx_valid)
                  pay_q <= pay_q + RAM_AW'(1);
               if (xfer_done)
                  state_q <= ST_WBACK;
               else
                  state_q <= ST_MOVE;
            end
            ST_WBACK: state_q <= ST_NEXT;
            ST_NEXT:
            begin
               // Stop after the record marked last [RULE19]
               if (hdr0_q[24 + BIT_LAST])
                  state_q <= ST_IDLE;
               else
               begin
                  // First word of the next record, read ahead on port b
                  desc_q  <= desc_q + rec_words;
                  hdr0_q  <= b_rdata;
                  state_q <= ST_FETCH;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Result capture
   // ------------------------------------------------------------
   // Status, count and toggle latched at completion [RULE7] [RULE8]
   // The result branch outranks the start clear, so a fault is not lost when both come in one cycle
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         status_q <= status_ok;
         count_q  <= '0;
         toggle_q <= 1'b0;
         fault_q  <= 1'b0;
      end
      else if (state_q == ST_FETCH)
         toggle_q <= hdr0_q[8 + BIT_TOGGLE];
      else if ((state_q == ST_WAIT || state_q == ST_MOVE) && xfer_done)
      begin
         status_q <= done_status;
         count_q  <= xfer_count;
         fault_q  <= fault_q | (done_status != status_ok);
         if (xfer_data_rx)
            toggle_q <= xfer_toggle_next; // [RULE17]
      end
      else if (start_pulse)
         fault_q  <= 1'b0;
   end

endmodule

// ===== logic/tdc_pkg.sv
// Package for the transfer descriptor codec: header layout, status codes,
// register offsets and reset values.
// Assumes a word-wide view of the buffer RAM inside the codec.
package tdc_pkg;

   // ------------------------------------------------------------
   // Header geometry
   // ------------------------------------------------------------
   localparam int unsigned HDR_BYTES      = 8;
   localparam int unsigned RAM_WORDS      = 64;
   localparam int unsigned RAM_AW         = 6;
   localparam int unsigned BYTE_AW        = 8;

   // Byte positions inside the header
   localparam logic [2:0] HB_COUNT_LO     = 3'h0;
   localparam logic [2:0] HB_STATUS       = 3'h1;
   localparam logic [2:0] HB_MAXPKT_LO    = 3'h2;
   localparam logic [2:0] HB_ENDPOINT     = 3'h3;
   localparam logic [2:0] HB_LEN_LO       = 3'h4;
   localparam logic [2:0] HB_LEN_HI       = 3'h5;
   localparam logic [2:0] HB_ADDR         = 3'h6;

   // Bit positions in bytes 1, 3 and 5
   localparam int unsigned BIT_ACTIVE     = 3;
   localparam int unsigned BIT_TOGGLE     = 2;
   localparam int unsigned BIT_LAST       = 3;
   localparam int unsigned BIT_SPEED      = 2;
   localparam int unsigned BIT_DIR        = 4;

   // ------------------------------------------------------------
   // Completion status encodings
   // ------------------------------------------------------------
   localparam logic [3:0] status_ok              = 4'h0;
   localparam logic [3:0] status_crc             = 4'h1;
   localparam logic [3:0] status_stuff_violation = 4'h2;
   localparam logic [3:0] status_toggle_mismatch = 4'h3;
   localparam logic [3:0] status_stall           = 4'h4;
   localparam logic [3:0] status_no_response     = 4'h5;
   localparam logic [3:0] status_pid_check_fail  = 4'h6;
   localparam logic [3:0] status_bad_pid         = 4'h7;
   localparam logic [3:0] status_data_over       = 4'h8;
   localparam logic [3:0] status_data_under      = 4'h9;
   localparam logic [3:0] status_buffer_over     = 4'hc;
   localparam logic [3:0] status_buffer_under    = 4'hd;

   // ------------------------------------------------------------
   // Register map (word registers, byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CONTROL     = 8'h00;
   localparam logic [7:0] REG_STATUS      = 8'h04;
   localparam logic [7:0] REG_RAM_PTR     = 8'h08;
   localparam logic [7:0] REG_RAM_DATA    = 8'h0c;
   localparam logic [7:0] REG_CUR_DESC    = 8'h10;
   localparam logic [31:0] RESET_VALUE    = 32'h0000_0000;

   // Control bits
   localparam int unsigned CTL_START      = 0;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_FETCH  = 3'b001,
      ST_ISSUE  = 3'b011,
      ST_WAIT   = 3'b010,
      ST_MOVE   = 3'b110,
      ST_WBACK  = 3'b111,
      ST_NEXT   = 3'b101
   } tdc_state_type;

endpackage

// ===== logic/tdc_ram.sv
// Word-wide buffer RAM held in flip-flops with two ports.
// Assumes one writer per port per cycle; port a wins on a collision.
`timescale 1ns/100ps
module tdc_ram
   import tdc_pkg::*;
(
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst,
   // Port a
   input  wire logic [RAM_AW-1:0] a_addr,
   input  wire logic              a_we,
   input  wire logic [31:0]       a_wdata,
   output logic      [31:0]       a_rdata,
   // Port b
   input  wire logic [RAM_AW-1:0] b_addr,
   input  wire logic              b_we,
   input  wire logic [31:0]       b_wdata,
   output logic      [31:0]       b_rdata
);

   logic [31:0] mem_q [RAM_WORDS];

   // ------------------------------------------------------------
   // Storage, one generate entry per word
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < RAM_WORDS; gi++)
      begin : g_word
         always_ff @(posedge clock or posedge rst)
         begin
            if (rst)
               mem_q[gi] <= RESET_VALUE;
            else if (a_we && a_addr == RAM_AW'(gi))
               mem_q[gi] <= a_wdata;
            else if (b_we && b_addr == RAM_AW'(gi))
               mem_q[gi] <= b_wdata;
         end
      end
   endgenerate

   // Combinational reads; callers register as needed
   assign a_rdata = mem_q[a_addr];
   assign b_rdata = mem_q[b_addr];

endmodule

// ===== sim/tdc_properties.sv
// Port checker for the descriptor codec.
// Assumes a bind onto tdc_codec, one clock, async reset.
`timescale 1ns/100ps
module tdc_properties
   import tdc_pkg::*;
(
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst,
   // Register port
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [31:0] reg_rdata,
   // Link side
   input wire logic        xfer_req,
   input wire logic [3:0]  xfer_endpoint_index,
   input wire logic [9:0]  xfer_requested_length,
   input wire logic        xfer_done,
   input wire logic        list_busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   // Transfer open from request to result
   logic wait_q;
   always_ff @(posedge clock or posedge rst)
      if (rst)
         wait_q <= 1'b0;
      else if (xfer_req)
         wait_q <= 1'b1;
      else if (xfer_done)
         wait_q <= 1'b0;

   // --------------------------------------
   // Steps of a list walk
   // --------------------------------------
   sequence start_s;
      reg_write && reg_addr == REG_CONTROL && reg_wdata[0] && !list_busy;
   endsequence
   sequence issue_s;
      xfer_req ##1 !xfer_req;
   endsequence

   start_busy_a: assert property (start_s |=> list_busy)
      else $error("start did not raise busy");
   req_pulse_a: assert property (xfer_req |-> issue_s)
      else $error("request longer than one cycle");
   req_order_a: assert property (xfer_req |-> list_busy && !wait_q)
      else $error("request while another is open");
   field_hold_a: assert property
      (wait_q |-> $stable(xfer_endpoint_index) && $stable(xfer_requested_length))
      else $error("transfer fields moved while open");
   done_gap_a: assert property (xfer_done |=> (!xfer_req)[*2])
      else $error("request before write-back");
   busy_read_a: assert property
      (reg_read && reg_addr == REG_CONTROL |=> reg_rdata[0] == $past(list_busy))
      else $error("busy bit wrong");
   unmapped_zero_a: assert property
      (reg_read && reg_addr >= 8'h14 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   rdata_idle_a: assert property (!reg_read |=> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
endmodule

// ===== sim/tdc_link_model.sv
// Link engine stand-in: answers each request after a set delay.
// Assumes the bench picks status, count, delay and IN data word.
`timescale 1ns/100ps
module tdc_link_model
(
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst,
   // Request from codec
   input wire logic        xfer_req,
   input wire logic        xfer_dir_in,
   input wire logic        xfer_toggle,
   // Outcome chosen by the bench
   input wire logic [3:0]  set_status,
   input wire logic [9:0]  set_count,
   input wire logic [7:0]  set_delay,
   input wire logic [31:0] set_word,
   // Toward codec
   output logic            tx_take,
   output logic            rx_valid,
   output logic [31:0]     rx_data,
   output logic            xfer_done,
   output logic [3:0]      xfer_status,
   output logic [9:0]      xfer_count,
   output logic            xfer_data_rx,
   output logic            xfer_toggle_next
);
   logic [7:0] left_q;
   logic       busy_q;
   logic       in_q;
   logic       first_q;

   // Countdown per transfer; delay 1 is prompt, larger is slow
   always_ff @(posedge clock or posedge rst)
      if (rst)
      begin
         left_q  <= 8'h0;
         busy_q  <= 1'b0;
         in_q    <= 1'b0;
         first_q <= 1'b0;
      end
      else
      begin
         first_q <= xfer_req;
         if (xfer_req)
         begin
            busy_q <= 1'b1;
            left_q <= set_delay;
            in_q   <= xfer_dir_in;
         end
         else if (busy_q && left_q == 8'h0)
            busy_q <= 1'b0;
         else if (busy_q)
            left_q <= left_q - 8'h1;
      end

   // One payload word moves first; idle data is inverted, never stale
   assign rx_valid         = first_q & in_q;
   assign tx_take          = first_q & ~in_q;
   assign rx_data          = rx_valid ? set_word : ~set_word;
   assign xfer_done        = busy_q && left_q == 8'h0;
   assign xfer_status      = set_status;
   assign xfer_count       = set_count;
   assign xfer_data_rx     = in_q;
   assign xfer_toggle_next = ~xfer_toggle;
endmodule

// ===== sim/tdc_codec_test.sv
// Bench for the descriptor codec: loads records, runs lists, reads back.
// Assumes the link model in tdc_link_model.sv and the checker bound below.
`timescale 1ns/100ps
module tdc_codec_test
   import tdc_pkg::*;
;
   logic        clock, rst, reg_write, reg_read, xfer_req, list_busy;
   logic [7:0]  reg_addr, set_delay;
   logic [31:0] reg_wdata, reg_rdata, rx_data, set_word, tx_data;
   logic        tx_take, rx_valid, xfer_done, xfer_data_rx, xfer_toggle_next;
   logic [3:0]  xfer_status, xfer_endpoint_index, set_status;
   logic [9:0]  xfer_count, set_count, xfer_max_packet_length, xfer_requested_length;
   logic [6:0]  xfer_device_address_field;
   logic [1:0]  xfer_pid;
   logic        xfer_dir_in, xfer_speed, xfer_format, xfer_toggle, din;
   int          error_cnt, comparisons, n_req, n0;
   logic [3:0]  codes [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                               4'h6, 4'h7, 4'h8, 4'h9, 4'hc, 4'hd};

   // 200 MHz clock
   always #2.5 clock = ~clock;

   tdc_codec uut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .xfer_req(xfer_req), .xfer_endpoint_index(xfer_endpoint_index),
      .xfer_device_address_field(xfer_device_address_field), .xfer_pid(xfer_pid),
      .xfer_dir_in(xfer_dir_in), .xfer_speed(xfer_speed), .xfer_format(xfer_format),
      .xfer_toggle(xfer_toggle), .xfer_max_packet_length(xfer_max_packet_length),
      .xfer_requested_length(xfer_requested_length), .tx_data(tx_data), .tx_take(tx_take),
      .rx_valid(rx_valid), .rx_data(rx_data), .xfer_done(xfer_done),
      .xfer_status(xfer_status), .xfer_count(xfer_count), .xfer_data_rx(xfer_data_rx),
      .xfer_toggle_next(xfer_toggle_next), .list_busy(list_busy));

   tdc_link_model link (.clock(clock), .rst(rst), .xfer_req(xfer_req),
      .xfer_dir_in(xfer_dir_in), .xfer_toggle(xfer_toggle), .set_status(set_status),
      .set_count(set_count), .set_delay(set_delay), .set_word(set_word),
      .tx_take(tx_take), .rx_valid(rx_valid), .rx_data(rx_data), .xfer_done(xfer_done),
      .xfer_status(xfer_status), .xfer_count(xfer_count), .xfer_data_rx(xfer_data_rx),
      .xfer_toggle_next(xfer_toggle_next));

   // --------------------------------------
   // Helpers
   // --------------------------------------
   task chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Gap cycle after each strobe so no signal is set twice in one step
   task wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      @(posedge clock);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, e);
      @(posedge clock);
   endtask

   function automatic logic [31:0] hdr0(logic l, logic a, logic [3:0] s, logic t,
                                        logic [9:0] c);
      return {4'h5, l, 1'b1, 2'h1, 8'h40, s, a, t, c};
   endfunction

   function automatic logic [31:0] hdr1(logic d);
      return {8'h00, 1'b0, 7'h2a, 3'h0, d, 2'h1, 10'h004};
   endfunction

   // Only the two header words written before start; the one payload word is left as is
   task load(input logic [7:0] i, input logic l, input logic a, input logic d);
      wr(REG_RAM_PTR, {24'h0, i});
      wr(REG_RAM_DATA, hdr0(l, a, 4'h0, 1'b0, 10'h0));
      wr(REG_RAM_DATA, hdr1(d));
   endtask

   task run;
      int n;
      wr(REG_CONTROL, 32'h1);
      n = 0;
      do
      begin
         @(posedge clock);
         #1 n++;
      end
      while (list_busy !== 1'b0 && n < 400);
      if (n >= 400)
      begin
         chk(32'h1, 32'h0);
         summarize;
      end
      else
         @(posedge clock);
   endtask

   task summarize;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Request fields taken from header at each issue
   always @(negedge clock)
      if (xfer_req === 1'b1)
      begin
         n_req++;
         chk({xfer_endpoint_index, xfer_device_address_field, xfer_max_packet_length,
              xfer_requested_length, xfer_dir_in}, {4'h5, 7'h2a, 10'h140, 10'h4, din});
         chk({xfer_pid, xfer_speed, xfer_format, xfer_toggle}, 5'h0c);
      end

   // OUT payload is the word that the previous IN run left behind
   always @(negedge clock)
      if (tx_take === 1'b1)
         chk(tx_data, set_word ^ 32'h1);

   // --------------------------------------
   // Tests
   // --------------------------------------
   initial
   begin
      {clock, reg_write, reg_read, reg_addr, reg_wdata, din} = '0;
      {set_status, set_count, set_delay, set_word} = '0;
      {error_cnt, comparisons, n_req} = '0;
      rst = 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      wr(8'h40, 32'hffff_ffff);
      rd(REG_CONTROL, 32'h0);
      rd(8'h14, 32'h0);
      $display("test register port done");
      // Every status code, IN and OUT alternating, prompt and slow answers
      for (int i = 0; i < 12; i++)
      begin
         din = ~i[0];
         set_status <= codes[i];
         set_count <= 10'h2c0 | {6'h0, codes[i]};
         set_delay <= i[0] ? 8'd20 : 8'd1;
         set_word <= 32'hc0de_0000 | i;
         load(8'h0, 1'b1, 1'b1, din);
         run;
         wr(REG_RAM_PTR, 32'h0);
         rd(REG_RAM_DATA, hdr0(1'b1, 1'b0, codes[i], din, 10'h2c0 | codes[i]));
         rd(REG_RAM_DATA, hdr1(din));
         if (din)
            rd(REG_RAM_DATA, 32'hc0de_0000 | i);
         $display("test status %h done", codes[i]);
      end
      // Inactive record skipped, list stops at last
      din = 1'b1;
      set_status <= 4'ha; // Reserved code, folds to bad PID
      load(8'h0, 1'b0, 1'b0, 1'b1);
      load(8'h3, 1'b1, 1'b1, 1'b1);
      load(8'h6, 1'b1, 1'b1, 1'b1);
      n0 = n_req;
      run;
      chk(n_req - n0, 32'h1);
      rd(REG_STATUS, 32'h0000_21c0);
      rd(REG_CUR_DESC, 32'h0000_0003);
      wr(REG_RAM_PTR, 32'h0);
      rd(REG_RAM_DATA, hdr0(1'b0, 1'b0, 4'h0, 1'b0, 10'h0));
      wr(REG_RAM_PTR, 32'h3);
      rd(REG_RAM_DATA, hdr0(1'b1, 1'b0, 4'h7, 1'b1, 10'h2cd));
      wr(REG_RAM_PTR, 32'h6);
      rd(REG_RAM_DATA, hdr0(1'b1, 1'b1, 4'h0, 1'b0, 10'h0));
      rd(REG_RAM_PTR, 32'h0000_0007);
      $display("test list walk done");
      summarize;
   end
endmodule

bind tdc_codec tdc_properties props (.clock(clock), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .xfer_req(xfer_req), .xfer_endpoint_index(xfer_endpoint_index),
   .xfer_requested_length(xfer_requested_length), .xfer_done(xfer_done),
   .list_busy(list_busy));
